// *** rtl/pts_pkg.sv ***
/*
  constants shared by the pcm time slot configuration block:
  register indices and byte addresses, field positions, reset values
  and word lengths. assumes byte address = four times register index.
*/
package pts_pkg;
  // ****************************************
  // register indices and byte addresses
  // ****************************************
  localparam logic [5:0] LEFT_IDX = 6'h3b;
  localparam logic [5:0] MISC_IDX = 6'h3c;
  localparam logic [5:0] RIGHT_IDX = 6'h3d;
  localparam logic [5:0] REV_IDX = 6'h3e;
  localparam logic [5:0] ID_IDX = 6'h3f;
  localparam logic [7:0] LEFT_ADDR = {LEFT_IDX, 2'h0};
  localparam logic [7:0] MISC_ADDR = {MISC_IDX, 2'h0};
  localparam logic [7:0] RIGHT_ADDR = {RIGHT_IDX, 2'h0};
  localparam logic [7:0] REV_ADDR = {REV_IDX, 2'h0};
  localparam logic [7:0] ID_ADDR = {ID_IDX, 2'h0};

  // ****************************************
  // reset values and field positions
  // ****************************************
  localparam logic [8:0] LEFT_RST = 9'h000;
  localparam logic [8:0] MISC_RST = 9'h020;
  localparam logic [8:0] RIGHT_RST = 9'h000;
  localparam int SLOT_EN_BIT = 8;
  localparam int SHORT_BIT = 6;
  localparam int RMSB_BIT = 1;
  localparam int LMSB_BIT = 0;

  // ****************************************
  // link timing in bit periods, and the config crossing width
  // ****************************************
  localparam logic [10:0] STD_START = 11'h001;
  localparam logic [10:0] POS_IDLE = 11'h7ff;
  localparam logic [5:0] LEN_SHORT = 6'h08;
  localparam logic [5:0] LEN_16 = 6'h10;
  localparam logic [5:0] LEN_20 = 6'h14;
  localparam logic [5:0] LEN_24 = 6'h18;
  localparam logic [5:0] LEN_32 = 6'h20;
  localparam int CFG_W = 25;
endpackage : pts_pkg

// *** rtl/pts_sync2.sv ***
/*
  two flip-flop synchroniser for a vector of quasi-static levels.
  assumes each bit is stable for several destination clock periods.
*/
`timescale 1ns/100ps
module pts_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : pts_sync2

// *** rtl/pts_slot_capture.sv ***
/*
  shifts one channel's sample off the serial data line while the bit
  position lies inside the channel's slot. assumes pos counts bit
  periods from frame sync, zero at the frame sync bit itself.
*/
`timescale 1ns/100ps
module pts_slot_capture (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic frame_start,
  input wire logic [10:0] pos,
  input wire logic [10:0] start,
  input wire logic [5:0] len,
  input wire logic sd,
  output logic [31:0] word_q,
  output logic done_q
);
  logic [10:0] stop;
  logic in_slot;
  logic last;
  logic [31:0] base;

  // slot window and its last bit
  assign stop = start + {5'h00, len};
  assign in_slot = (pos >= start) && (pos < stop);
  assign last = in_slot && (pos == stop - 11'h001);
  assign base = frame_start ? 32'h0000_0000 : word_q;

  // msb first shift, cleared at each frame sync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= 32'h0000_0000;
    end else if (ce) begin
      word_q <= in_slot ? {base[30:0], sd} : base;
    end
  end

  // one pulse after the last bit is in
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= last;
    end
  end
endmodule : pts_slot_capture

// *** rtl/pts_pcm_time_slot_config.sv ***
/*
  pcm time slot configuration block: apb register file with slot
  start counts, slot and short word controls, revision and identity,
  plus the link side that places and captures both channels.
  assumes apb on pclk, bit clock bclk from the host, frame sync and
  serial data launched by the host so they are stable at bclk rise.
*/
// The APB slave port was left to the implementer.
// Behaviour
// (R1) Left data starts a 10-bit bit count after frame sync, low nine bits from the left register.
// (R2) Right data starts a 10-bit bit count after frame sync, low nine bits from the right register.
// (R3) The slot counts apply only while slot mode is enabled and the port is in pcm mode.
// (R4) With short word select set each channel carries an 8-bit word.
// (R5) A read-only revision register returns a fixed value and ignores writes.
// (R6) A read-only identity register returns a fixed 7-bit value.
// (R7) With slot mode off, data sits at the standard position and both counts are ignored.
`timescale 1ns/100ps
module pts_pcm_time_slot_config #(
  parameter logic [8:0] SILICON_REVISION_VALUE = 9'h003, // arbitrary value
  parameter logic [6:0] PART_IDENTITY_VALUE = 7'h2c // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pcm_mode_sel,
  input wire logic [1:0] word_len_sel,
  input wire logic bclk,
  input wire logic fsync,
  input wire logic sdin,
  output logic [31:0] left_sample,
  output logic [31:0] right_sample,
  output logic sample_valid
);
  // ****************************************
  // register file on pclk
  // ****************************************
  logic [8:0] left_slot_start_low_q;
  logic [8:0] slot_word_misc_control_q;
  logic [8:0] right_slot_start_low_q;
  logic access;
  logic wr_commit;
  logic mapped;
  logic [31:0] rd_d;

  // access phase before the answer, and the commit edge
  assign access = ce && psel && penable && !pready;
  assign wr_commit = ce && psel && penable && pready && pwrite;

  // read decode; revision and identity come from constants
  always_comb begin
    mapped = 1'b1;
    rd_d = 32'h0000_0000;
    unique case (paddr)
      pts_pkg::LEFT_ADDR: rd_d[8:0] = left_slot_start_low_q;
      pts_pkg::MISC_ADDR: rd_d[8:0] = slot_word_misc_control_q;
      pts_pkg::RIGHT_ADDR: rd_d[8:0] = right_slot_start_low_q;
      // (R5) fixed revision
      pts_pkg::REV_ADDR: rd_d[8:0] = SILICON_REVISION_VALUE;
      // (R6) fixed identity
      pts_pkg::ID_ADDR: rd_d[6:0] = PART_IDENTITY_VALUE;
      default: mapped = 1'b0;
    endcase
  end

  // one wait state, then the answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= access;
      prdata <= access ? rd_d : 32'h0000_0000;
      pslverr <= access && !mapped;
    end
  end

  // writable registers; writes to revision and identity are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_slot_start_low_q <= pts_pkg::LEFT_RST;
      slot_word_misc_control_q <= pts_pkg::MISC_RST;
      right_slot_start_low_q <= pts_pkg::RIGHT_RST;
    end else if (wr_commit) begin
      if (paddr == pts_pkg::LEFT_ADDR) begin
        left_slot_start_low_q <= pwdata[8:0];
      end
      if (paddr == pts_pkg::MISC_ADDR) begin
        slot_word_misc_control_q <= pwdata[8:0];
      end
      if (paddr == pts_pkg::RIGHT_ADDR) begin
        right_slot_start_low_q <= pwdata[8:0];
      end
    end
  end

  // ****************************************
  // crossing into the bit clock domain
  // ****************************************
  logic link_rst_n;
  logic ce_l;
  logic [pts_pkg::CFG_W-1:0] cfg_p;
  logic [pts_pkg::CFG_W-1:0] cfg_l;

  // reset released on bclk, asserted at once
  pts_sync2 #(.WIDTH(1)) u_rst_sync (
    .clk(bclk),
    .rst_n(presetn),
    .d(1'b1),
    .q(link_rst_n)
  );

  pts_sync2 #(.WIDTH(1)) u_ce_sync (
    .clk(bclk),
    .rst_n(presetn),
    .d(ce),
    .q(ce_l)
  );

  // configuration is quasi-static, changed only between frames
  assign cfg_p = {pcm_mode_sel, word_len_sel,
                  slot_word_misc_control_q[pts_pkg::SLOT_EN_BIT],
                  slot_word_misc_control_q[pts_pkg::SHORT_BIT],
                  slot_word_misc_control_q[pts_pkg::RMSB_BIT], right_slot_start_low_q,
                  slot_word_misc_control_q[pts_pkg::LMSB_BIT], left_slot_start_low_q};

  pts_sync2 #(.WIDTH(pts_pkg::CFG_W)) u_cfg_sync (
    .clk(bclk),
    .rst_n(presetn),
    .d(cfg_p),
    .q(cfg_l)
  );

  // ****************************************
  // slot placement on bclk
  // ****************************************
  logic cfg_pcm;
  logic [1:0] cfg_wl;
  logic slot_mode_enable;
  logic short_word_select;
  logic [9:0] left_slot_start_count;
  logic [9:0] right_slot_start_count;
  logic use_slots;
  logic [5:0] len;
  logic [5:0] base_len;
  logic [10:0] left_start;
  logic [10:0] right_start;

  assign cfg_pcm = cfg_l[24];
  assign cfg_wl = cfg_l[23:22];
  assign slot_mode_enable = cfg_l[21];
  assign short_word_select = cfg_l[20];
  assign right_slot_start_count = cfg_l[19:10];
  assign left_slot_start_count = cfg_l[9:0];

  // word length from the interface setting
  always_comb begin
    unique case (cfg_wl)
      2'h0: base_len = pts_pkg::LEN_16;
      2'h1: base_len = pts_pkg::LEN_20;
      2'h2: base_len = pts_pkg::LEN_24;
      default: base_len = pts_pkg::LEN_32;
    endcase
  end

  // (R4) short word override
  assign len = short_word_select ? pts_pkg::LEN_SHORT : base_len;

  // (R3) counts only in pcm mode with slots enabled
  assign use_slots = slot_mode_enable && cfg_pcm;

  // (R1) left start from nine low bits plus the high bit
  // (R7) standard position when slots are off
  assign left_start = use_slots ? {1'b0, left_slot_start_count} : pts_pkg::STD_START;

  // (R2) right start from nine low bits plus the high bit
  // (R7) right follows left in the standard frame
  assign right_start = use_slots ? {1'b0, right_slot_start_count}
                                 : pts_pkg::STD_START + {5'h00, len};

  // ****************************************
  // link pins and bit position on bclk
  // ****************************************
  logic fs_q;
  logic fs_prev_q;
  logic sd_q;
  logic fs_edge;
  logic [10:0] cnt_q;
  logic [10:0] pos;

  // sample the host's pins on bclk rise
  always_ff @(posedge bclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fs_q <= 1'b0;
      fs_prev_q <= 1'b0;
      sd_q <= 1'b0;
    end else if (ce_l) begin
      fs_q <= fsync;
      fs_prev_q <= fs_q;
      sd_q <= sdin;
    end
  end

  assign fs_edge = fs_q && !fs_prev_q;
  assign pos = fs_edge ? 11'h000 : cnt_q;

  // bit count from frame sync, parked until the first frame
  always_ff @(posedge bclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_q <= pts_pkg::POS_IDLE;
    end else if (ce_l) begin
      if (fs_edge) begin
        cnt_q <= 11'h001;
      end else if (cnt_q != pts_pkg::POS_IDLE) begin
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end

  // ****************************************
  // channel capture
  // ****************************************
  logic [31:0] l_word;
  logic [31:0] r_word;
  logic l_done;
  logic r_done;

  pts_slot_capture u_left (
    .clk(bclk),
    .rst_n(link_rst_n),
    .ce(ce_l),
    .frame_start(fs_edge),
    .pos(pos),
    .start(left_start),
    .len(len),
    .sd(sd_q),
    .word_q(l_word),
    .done_q(l_done)
  );

  pts_slot_capture u_right (
    .clk(bclk),
    .rst_n(link_rst_n),
    .ce(ce_l),
    .frame_start(fs_edge),
    .pos(pos),
    .start(right_start),
    .len(len),
    .sd(sd_q),
    .word_q(r_word),
    .done_q(r_done)
  );

  // ****************************************
  // frame hand-off to pclk
  // ****************************************
  logic l_got_q;
  logic r_got_q;
  logic sent_q;
  logic fire;
  logic tgl_q;
  logic [31:0] hold_l_q;
  logic [31:0] hold_r_q;

  assign fire = l_got_q && r_got_q && !sent_q && !fs_edge;

  // both channels in, once per frame
  always_ff @(posedge bclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l_got_q <= 1'b0;
      r_got_q <= 1'b0;
      sent_q <= 1'b0;
    end else if (ce_l) begin
      l_got_q <= !fs_edge && (l_got_q || l_done);
      r_got_q <= !fs_edge && (r_got_q || r_done);
      sent_q <= !fs_edge && (sent_q || fire);
    end
  end

  // hold words stable while the toggle crosses
  always_ff @(posedge bclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      hold_l_q <= 32'h0000_0000;
      hold_r_q <= 32'h0000_0000;
      tgl_q <= 1'b0;
    end else if (ce_l && fire) begin
      hold_l_q <= l_word;
      hold_r_q <= r_word;
      tgl_q <= !tgl_q;
    end
  end

  logic tgl_s;
  logic tgl_prev_q;

  pts_sync2 #(.WIDTH(1)) u_tgl_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(tgl_q),
    .q(tgl_s)
  );

  // toggle change loads the sample pair and pulses valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgl_prev_q <= 1'b0;
      left_sample <= 32'h0000_0000;
      right_sample <= 32'h0000_0000;
      sample_valid <= 1'b0;
    end else if (ce) begin
      tgl_prev_q <= tgl_s;
      sample_valid <= tgl_s != tgl_prev_q;
      if (tgl_s != tgl_prev_q) begin
        left_sample <= hold_l_q;
        right_sample <= hold_r_q;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  AST_LEFT_SLOT_END: assert property ( // R1
    @(posedge bclk) disable iff (!link_rst_n)
    ce_l && use_slots && !fs_edge
      && pos == {1'b0, left_slot_start_count} + {5'h00, len} - 11'h001
    |=> l_done)
    else $error("left word not done at its programmed slot end");

  AST_RIGHT_SLOT_END: assert property ( // R2
    @(posedge bclk) disable iff (!link_rst_n)
    ce_l && use_slots && !fs_edge
      && pos == {1'b0, right_slot_start_count} + {5'h00, len} - 11'h001
    |=> r_done)
    else $error("right word not done at its programmed slot end");

  AST_NO_SLOT_OUTSIDE_PCM: assert property ( // R3
    @(posedge bclk) disable iff (!link_rst_n)
    ce_l && !cfg_pcm && !fs_edge
      && pos == pts_pkg::STD_START + {5'h00, len} - 11'h001
    |=> l_done)
    else $error("left word moved off standard position outside pcm mode");

  AST_SHORT_WORD: assert property ( // R4
    @(posedge bclk) disable iff (!link_rst_n)
    ce_l && short_word_select && !fs_edge && pos == left_start + 11'h007
    |=> l_done)
    else $error("short word did not end after eight bits");

  AST_REV_READ: assert property ( // R5
    @(posedge pclk) disable iff (!presetn)
    access && paddr == pts_pkg::REV_ADDR
    |=> pready && prdata == {23'h000000, SILICON_REVISION_VALUE} && !pslverr)
    else $error("revision readback wrong");

  AST_ID_READ: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    access && paddr == pts_pkg::ID_ADDR
    |=> pready && prdata == {25'h0000000, PART_IDENTITY_VALUE})
    else $error("identity readback wrong");

  AST_STD_POSITION: assert property ( // R7
    @(posedge bclk) disable iff (!link_rst_n)
    ce_l && !slot_mode_enable && !fs_edge
      && pos == pts_pkg::STD_START + {4'h0, len, 1'b0} - 11'h001
    |=> r_done)
    else $error("right word not at standard position");

  AST_LEFT_WRITE: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    wr_commit && paddr == pts_pkg::LEFT_ADDR
    |=> left_slot_start_low_q == $past(pwdata[8:0]))
    else $error("left slot start write lost");

  COV_SLOT_FRAME: cover property (
    @(posedge bclk) disable iff (!link_rst_n) use_slots && fire);
  COV_STD_FRAME: cover property (
    @(posedge bclk) disable iff (!link_rst_n) !use_slots && fire);
  COV_SHORT_FRAME: cover property (
    @(posedge bclk) disable iff (!link_rst_n) short_word_select && fire);
  COV_UNMAPPED: cover property (
    @(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule : pts_pcm_time_slot_config

// *** test/pts_host_model.sv ***
/*
  host side model of the pcm link: makes the bit clock, frame sync and
  serial data of one frame per call of send_frame.
  assumes the bench alone calls send_frame and nothing else drives the lines.
*/
`timescale 1ns/100ps
module pts_host_model (
  output logic bclk,
  output logic fsync,
  output logic sdin
);
  // ****************************************
  // idle levels
  // ****************************************
  // bit clock stands still between frames
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
    sdin = 1'b0;
  end

  // ****************************************
  // frame generator
  // ****************************************
  // one 80 ns bit period, lines change while bclk is low
  task automatic bit_time(input logic fs, input logic d);
    fsync = fs;
    sdin = d;
    #40 bclk = 1'b1;
    #40 bclk = 1'b0;
  endtask : bit_time

  // lead-in bits let the link leave reset and pick up config,
  // tail bits carry the samples across to pclk
  task automatic send_frame(input logic [31:0] lw, input logic [31:0] rw, input int ls,
                            input int rs, input int len, input int total);
    int p;
    logic d;
    #13;
    for (p = -6; p < total + 4; p++) begin
      d = ~sdin; // bits outside the slots toggle every period
      if (p >= ls && p < ls + len) d = lw[len - 1 - (p - ls)];
      if (p >= rs && p < rs + len) d = rw[len - 1 - (p - rs)];
      bit_time(p == 0, d);
    end
    sdin = ~sdin; // released line does not keep the last bit
  endtask : send_frame
endmodule : pts_host_model

// *** test/testbench.sv ***
/*
  self-checking bench for the pcm time slot configuration block:
  apb register accesses and whole link frames from the host model.
  assumes the design package is compiled first.
*/
`timescale 1ns/100ps
module testbench;
  localparam logic [8:0] REV_VAL = 9'h003; // arbitrary value
  localparam logic [6:0] ID_VAL = 7'h2c; // arbitrary value
  logic pclk, presetn, ce, psel, penable, pwrite, pcm_mode_sel;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, left_sample, right_sample;
  logic pready, pslverr, bclk, fsync, sdin, sample_valid;
  logic [1:0] word_len_sel;
  int num_errors = 0;
  int num_checks = 0;
  int valid_count = 0;
  int lens[4] = '{16, 20, 24, 32};

  // ****************************************
  // clock, design and host
  // ****************************************
  // 20 mhz apb clock
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  pts_pcm_time_slot_config #(
    .SILICON_REVISION_VALUE(REV_VAL),
    .PART_IDENTITY_VALUE(ID_VAL)
  ) uut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pcm_mode_sel(pcm_mode_sel),
    .word_len_sel(word_len_sel), .bclk(bclk), .fsync(fsync), .sdin(sdin),
    .left_sample(left_sample), .right_sample(right_sample), .sample_valid(sample_valid)
  );

  pts_host_model host (.bclk(bclk), .fsync(fsync), .sdin(sdin));

  // counts sample updates away from the launching edge
  always @(negedge pclk) begin
    if (sample_valid === 1'b1) valid_count++;
  end

  // ****************************************
  // tasks
  // ****************************************
  // verdict and end of run
  task automatic stop_test;
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // compare and report
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    // sample pready, data and error at the rising edge itself
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [8:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {23'h7fffff, d}, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check("read data", exp, rd);
    check("slave error", {31'h0, exp_err}, {31'h0, err});
  endtask : rd_chk

  function automatic logic [31:0] msk(input int n);
    msk = (n >= 32) ? 32'hffff_ffff : ((32'h0000_0001 << n) - 32'h0000_0001);
  endfunction : msk

  // one frame from the host, then both samples compared
  task automatic frame(input int ls, input int rs, input int len, input int total);
    logic [31:0] lw, rw;
    int i;
    lw = 32'ha5c3_96f1;
    rw = 32'h5a3c_690e;
    valid_count = 0;
    host.send_frame(lw, rw, ls, rs, len, total);
    for (i = 0; i < 40 && valid_count == 0; i++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    check("sample updates", 32'h0000_0001, valid_count);
    check("left sample", lw & msk(len), left_sample);
    check("right sample", rw & msk(len), right_sample);
  endtask : frame

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pcm_mode_sel = 1'b1;
    word_len_sel = 2'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and read-only places
    rd_chk(pts_pkg::LEFT_ADDR, {23'h0, pts_pkg::LEFT_RST}, 1'b0);
    rd_chk(pts_pkg::MISC_ADDR, {23'h0, pts_pkg::MISC_RST}, 1'b0);
    rd_chk(pts_pkg::RIGHT_ADDR, {23'h0, pts_pkg::RIGHT_RST}, 1'b0);
    wr(pts_pkg::REV_ADDR, 9'h1ff);
    wr(pts_pkg::ID_ADDR, 9'h1ff);
    rd_chk(pts_pkg::REV_ADDR, {23'h0, REV_VAL}, 1'b0);
    rd_chk(pts_pkg::ID_ADDR, {25'h0, ID_VAL}, 1'b0);
    wr(8'h00, 9'h1ff);
    rd_chk(8'h00, 32'h0000_0000, 1'b1);
    wr(pts_pkg::LEFT_ADDR, 9'h005);
    wr(pts_pkg::RIGHT_ADDR, 9'h007);
    rd_chk(pts_pkg::LEFT_ADDR, 32'h0000_0005, 1'b0);
    foreach (lens[k]) begin
      word_len_sel <= k[1:0];
      frame(1, 1 + lens[k], lens[k], 2 + 2 * lens[k]);
    end
    // enable without pcm mode keeps standard place
    word_len_sel <= 2'h0;
    pcm_mode_sel <= 1'b0;
    wr(pts_pkg::MISC_ADDR, 9'h120);
    frame(1, 17, 16, 34);
    pcm_mode_sel <= 1'b1;
    wr(pts_pkg::LEFT_ADDR, 9'h003);
    wr(pts_pkg::RIGHT_ADDR, 9'h004);
    wr(pts_pkg::MISC_ADDR, 9'h122);
    rd_chk(pts_pkg::MISC_ADDR, 32'h0000_0122, 1'b0);
    frame(3, 516, 16, 534);
    wr(pts_pkg::LEFT_ADDR, 9'h000);
    wr(pts_pkg::RIGHT_ADDR, 9'h000);
    wr(pts_pkg::MISC_ADDR, 9'h121);
    frame(512, 0, 16, 530);
    word_len_sel <= 2'h3;
    wr(pts_pkg::LEFT_ADDR, 9'h00a);
    wr(pts_pkg::RIGHT_ADDR, 9'h014);
    wr(pts_pkg::MISC_ADDR, 9'h160);
    frame(10, 20, 8, 30);
    stop_test();
  end
endmodule : testbench
